// File: verilog/crs_sequencer.sv
`timescale 1ns/1ns
module crs_sequencer #(
	parameter int NUM_DSP = crs_pkg::NUM_DSP,
	parameter int RELEASE_LIMIT = crs_pkg::RELEASE_CYCLES
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Reset pin and PLL lock indications
	input wire logic chip_reset_pin_low_n,
	input wire logic dsp_pll_locked,
	input wire logic audio_pll_locked,
	// Register port from the serial-bus slave
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_addr,
	input wire logic [crs_pkg::REG_W-1:0] reg_wdata,
	output logic [crs_pkg::REG_W-1:0] reg_rdata,
	// Processor side
	input wire logic [NUM_DSP-1:0] dsp_clk_stopped,
	output logic [NUM_DSP-1:0] dsp_pc_hold,
	output logic [NUM_DSP-1:0] supervisor_enable,
	// Chip-level reset outputs
	output logic periph_reset,
	output logic init_state,
	output logic seq_busy
);
	localparam int HW = $clog2(crs_pkg::LOCK_HOLD_CYCLES);
	localparam logic [HW-1:0] HOLD_LAST = HW'(crs_pkg::LOCK_HOLD_CYCLES - 1);
	localparam int RW = $clog2(RELEASE_LIMIT + 1);
	localparam logic [RW-1:0] REL_LAST = RW'(RELEASE_LIMIT);

	// Any state that keeps the chip in reset
	function automatic logic in_reset(input crs_pkg::crs_state_t s);
		return s == crs_pkg::CRS_PIN_LOW || s == crs_pkg::CRS_WAIT_LOCK || s == crs_pkg::CRS_HOLD;
	endfunction

	logic pin_valid;
	logic lock1_reg, lock2_reg;
	logic alock1_reg, alock2_reg;
	logic both_locked;
	crs_pkg::crs_state_t state_reg, state_next;
	logic [HW-1:0] hold_cnt_reg, hold_cnt_next;
	logic [RW-1:0] rel_cnt_reg, rel_cnt_next;
	logic late_reg, late_next;
	logic [crs_pkg::REG_W-1:0] run_reg, run_next;
	logic [crs_pkg::REG_W-1:0] rdata_next;
	logic [NUM_DSP-1:0] pc_hold_next, sup_en_next;
	logic run_wr, rst_next;
	logic [NUM_DSP-1:0] pc_hold_reg, sup_en_reg;
	logic periph_reset_reg, init_reg;
	logic [crs_pkg::REG_W-1:0] rdata_reg;

	// Pin filter with its own synchronizer
	crs_pulse_filter #(
		.LOW_CYCLES(crs_pkg::FILTER_LOW_CYCLES)
	) u_filter (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.chip_reset_pin_low_n(chip_reset_pin_low_n),
		.valid_low(pin_valid)
	);

	assign both_locked = lock2_reg && alock2_reg;
	assign run_wr = reg_wr && reg_addr == crs_pkg::RUN_CTRL_ADDR && !in_reset(state_reg);

	// Sequence state machine with hold and release counters
	always_comb begin
		state_next = state_reg;
		hold_cnt_next = hold_cnt_reg;
		rel_cnt_next = rel_cnt_reg;
		late_next = late_reg;
		case (state_reg)
			crs_pkg::CRS_PIN_LOW: begin
				if (!pin_valid) begin
					state_next = crs_pkg::CRS_WAIT_LOCK;
					rel_cnt_next = '0;
				end
			end
			crs_pkg::CRS_WAIT_LOCK: begin
				if (both_locked) begin
					state_next = crs_pkg::CRS_HOLD;
					hold_cnt_next = '0;
				end
			end
			crs_pkg::CRS_HOLD: begin
				if (hold_cnt_reg == HOLD_LAST) begin
					state_next = crs_pkg::CRS_INIT;
				end else begin
					hold_cnt_next = hold_cnt_reg + HW'(1);
				end
			end
			crs_pkg::CRS_INIT: begin
				if (run_wr && |reg_wdata[NUM_DSP-1:0]) begin
					state_next = crs_pkg::CRS_RUN;
				end
			end
			crs_pkg::CRS_RUN: begin
				state_next = crs_pkg::CRS_RUN;
			end
			default: begin
				state_next = crs_pkg::CRS_PIN_LOW;
			end
		endcase
		// Release time watch: flag a sequence that outlasts the expected duration
		if (state_reg == crs_pkg::CRS_WAIT_LOCK || state_reg == crs_pkg::CRS_HOLD) begin
			if (rel_cnt_reg == REL_LAST) begin
				late_next = 1'b1;
			end else begin
				rel_cnt_next = rel_cnt_reg + RW'(1);
			end
		end
		// A qualified low pin restarts from anywhere
		if (pin_valid) begin
			state_next = crs_pkg::CRS_PIN_LOW;
			late_next = 1'b0;
		end
	end

	// Run control register and derived processor controls
	always_comb begin
		rst_next = in_reset(state_next);
		run_next = run_reg;
		if (rst_next) begin
			run_next = crs_pkg::RUN_CTRL_RESET;
		end else if (run_wr) begin
			run_next = reg_wdata;
		end
		pc_hold_next = rst_next ? '1 : ~run_next[NUM_DSP-1:0];
		sup_en_next = ~(pc_hold_next | dsp_clk_stopped);
		rdata_next = rdata_reg;
		if (reg_rd) begin
			rdata_next = '0;
			if (reg_addr == crs_pkg::RUN_CTRL_ADDR) begin
				rdata_next = run_reg;
			end else if (reg_addr == crs_pkg::STATUS_ADDR) begin
				rdata_next[crs_pkg::ST_INIT_BIT] = state_reg == crs_pkg::CRS_INIT;
				rdata_next[crs_pkg::ST_LOCKED_BIT] = both_locked;
				rdata_next[crs_pkg::ST_LATE_BIT] = late_reg;
				rdata_next[crs_pkg::ST_BUSY_BIT] = in_reset(state_reg);
			end
		end
	end

	// State registers; power-on reset starts the sequence at the lock wait (CRS_WAIT_LOCK)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock1_reg <= 1'b0;
			lock2_reg <= 1'b0;
			alock1_reg <= 1'b0;
			alock2_reg <= 1'b0;
			state_reg <= crs_pkg::CRS_WAIT_LOCK;
			hold_cnt_reg <= '0;
			rel_cnt_reg <= '0;
			late_reg <= 1'b0;
			run_reg <= crs_pkg::RUN_CTRL_RESET;
			pc_hold_reg <= '1;
			sup_en_reg <= '0;
			periph_reset_reg <= 1'b1;
			init_reg <= 1'b0;
			rdata_reg <= '0;
		end else if (ce) begin
			lock1_reg <= dsp_pll_locked;
			lock2_reg <= lock1_reg;
			alock1_reg <= audio_pll_locked;
			alock2_reg <= alock1_reg;
			state_reg <= state_next;
			hold_cnt_reg <= hold_cnt_next;
			rel_cnt_reg <= rel_cnt_next;
			late_reg <= late_next;
			run_reg <= run_next;
			pc_hold_reg <= pc_hold_next;
			sup_en_reg <= sup_en_next;
			periph_reset_reg <= rst_next;
			init_reg <= state_next == crs_pkg::CRS_INIT;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	assign reg_rdata = rdata_reg;
	assign dsp_pc_hold = pc_hold_reg;
	assign supervisor_enable = sup_en_reg;
	assign periph_reset = periph_reset_reg;
	assign init_state = init_reg;
	assign seq_busy = periph_reset_reg;

	// Checks
	sequence s_hold_end;
		ce && state_reg == crs_pkg::CRS_HOLD && hold_cnt_reg == HOLD_LAST && !pin_valid;
	endsequence
	sequence s_lock_seen;
		ce && state_reg == crs_pkg::CRS_WAIT_LOCK && both_locked && !pin_valid;
	endsequence

	chk_pin_starts_reset: assert property (@(posedge clk) disable iff (rst)
		ce && pin_valid |=> state_reg == crs_pkg::CRS_PIN_LOW && periph_reset)
		else $error("qualified pin low did not start the sequence");
	chk_hold_after_lock: assert property (@(posedge clk) disable iff (rst)
		s_lock_seen |=> state_reg == crs_pkg::CRS_HOLD && hold_cnt_reg == '0)
		else $error("hold did not start on lock");
	chk_no_hold_unlocked: assert property (@(posedge clk) disable iff (rst)
		ce && state_reg == crs_pkg::CRS_WAIT_LOCK && !both_locked |=> state_reg != crs_pkg::CRS_HOLD)
		else $error("hold began without both locks");
	chk_init_after_hold: assert property (@(posedge clk) disable iff (rst)
		s_hold_end |=> init_state && !periph_reset)
		else $error("initialization state not entered after hold");
	chk_hold_length: assert property (@(posedge clk) disable iff (rst)
		$rose(init_state) |-> $past(hold_cnt_reg) == HOLD_LAST)
		else $error("internal reset hold length wrong");
	chk_regs_default: assert property (@(posedge clk) disable iff (rst)
		periph_reset |-> run_reg == crs_pkg::RUN_CTRL_RESET)
		else $error("run control not at default during reset");
	chk_pc_held: assert property (@(posedge clk) disable iff (rst)
		periph_reset |-> &dsp_pc_hold)
		else $error("program counter released during reset");
	chk_pc_release: assert property (@(posedge clk) disable iff (rst)
		ce && run_wr && !pin_valid |=> dsp_pc_hold == ~$past(reg_wdata[NUM_DSP-1:0]))
		else $error("program counter hold not following run control");
	chk_supervisor_off: assert property (@(posedge clk) disable iff (rst)
		ce |=> (supervisor_enable & (dsp_pc_hold | $past(dsp_clk_stopped))) == '0)
		else $error("supervisor enabled while processor held or stopped");
endmodule

// File: include/crs_pkg.sv
// How it works
// - Low reset pin starts the sequence
// - Sequence expected to end about 1.0 ms after release; late flag set if not
// - Low pulses under forty clocks are ignored
// - After both locks, hold reset 2047 clocks
// - Completed reset enters initialization state
// - Control registers return to defaults
// - Program counters held until run control written
// - Peripheral blocks and supervisor are reset
// - Supervisor off while processor reset or stopped
// - Counted clock is the crystal oscillator clock
package crs_pkg;
	// Register map
	localparam int REG_W = 24;
	localparam logic [23:0] RUN_CTRL_ADDR = 24'h00_0010;
	localparam logic [23:0] STATUS_ADDR = 24'h00_0011;
	localparam logic [23:0] RUN_CTRL_RESET = 24'h00_0000;
	// Status field positions
	localparam int ST_INIT_BIT = 0;
	localparam int ST_LOCKED_BIT = 1;
	localparam int ST_LATE_BIT = 2;
	localparam int ST_BUSY_BIT = 3;
	// Counts and times
	localparam int NUM_DSP = 2;
	localparam int FILTER_LOW_CYCLES = 40;
	localparam int LOCK_HOLD_CYCLES = 2047;
	localparam int CLK_FREQ_HZ = 25_000_000;
	localparam real RELEASE_TIME_MS = 1.0;
	localparam int RELEASE_CYCLES = int'($floor(RELEASE_TIME_MS * CLK_FREQ_HZ / 1000.0));
	// Sequencer states
	typedef enum logic [2:0] {
		CRS_PIN_LOW,
		CRS_WAIT_LOCK,
		CRS_HOLD,
		CRS_INIT,
		CRS_RUN
	} crs_state_t;
endpackage

// File: verilog/crs_pulse_filter.sv
`timescale 1ns/1ns
module crs_pulse_filter #(
	parameter int LOW_CYCLES = crs_pkg::FILTER_LOW_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Raw pin and qualified reset
	input wire logic chip_reset_pin_low_n,
	output logic valid_low
);
	localparam int CW = $clog2(LOW_CYCLES + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(LOW_CYCLES);

	logic sync1_reg, sync2_reg;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic valid_reg, valid_next;

	// Count consecutive low samples, saturating at the threshold
	always_comb begin
		cnt_next = cnt_reg;
		if (sync2_reg) begin
			cnt_next = '0;
		end else if (cnt_reg != CNT_FULL) begin
			cnt_next = cnt_reg + CW'(1);
		end
		valid_next = !sync2_reg && (cnt_next == CNT_FULL);
	end

	// Two-stage synchronizer and counter registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			cnt_reg <= '0;
			valid_reg <= 1'b0;
		end else if (ce) begin
			sync1_reg <= chip_reset_pin_low_n;
			sync2_reg <= sync1_reg;
			cnt_reg <= cnt_next;
			valid_reg <= valid_next;
		end
	end

	assign valid_low = valid_reg;

	chk_filter_min_low: assert property (@(posedge clk) disable iff (rst)
		$rose(valid_low) |-> cnt_reg == CNT_FULL && !$past(sync2_reg))
		else $error("reset qualified before the minimum low time");
endmodule

// File: verification/crs_host_model.sv
`timescale 1ns/1ns
module crs_host_model #(
	parameter int DSP_LOCK_DLY = 8,
	parameter int AUD_LOCK_DLY = 30
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin and lock indications
	output logic chip_reset_pin_low_n,
	output logic dsp_pll_locked,
	output logic audio_pll_locked
);
	int lock_cnt;
	// Pin idles high through its pull-up
	initial chip_reset_pin_low_n = 1'b1;
	// PLLs lose lock while the pin is low, relock at two speeds
	always @(posedge clk or posedge rst) begin
		if (rst || !chip_reset_pin_low_n) begin
			lock_cnt <= 0;
		end else if (lock_cnt < 4095) begin
			lock_cnt <= lock_cnt + 1;
		end
	end
	assign dsp_pll_locked = (lock_cnt >= DSP_LOCK_DLY);
	assign audio_pll_locked = (lock_cnt >= AUD_LOCK_DLY);
	// Pull the pin low for n clocks, clock already running
	task automatic pulse(input int n);
		@(posedge clk);
		#1 chip_reset_pin_low_n = 1'b0;
		repeat (n) @(posedge clk);
		#1 chip_reset_pin_low_n = 1'b1;
	endtask
endmodule

// File: verification/chip_reset_sequencer_tb.sv
`timescale 1ns/1ns
module chip_reset_sequencer_tb;
	localparam int AUD = 30;
	// Release limit below lock plus hold time, so the late flag sets
	localparam int REL = 2060;
	logic clk, rst, ce, reg_wr, reg_rd;
	logic [23:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [1:0] dsp_clk_stopped, dsp_pc_hold, supervisor_enable;
	logic pin_n, dsp_lk, aud_lk, periph_reset, init_state, seq_busy;
	int error_cnt, comparisons, cyc, n;
	crs_host_model #(.DSP_LOCK_DLY(8), .AUD_LOCK_DLY(AUD)) host (.clk(clk), .rst(rst),
		.chip_reset_pin_low_n(pin_n), .dsp_pll_locked(dsp_lk), .audio_pll_locked(aud_lk));
	crs_sequencer #(.RELEASE_LIMIT(REL)) DUT (.clk(clk), .rst(rst), .ce(ce), .chip_reset_pin_low_n(pin_n),
		.dsp_pll_locked(dsp_lk), .audio_pll_locked(aud_lk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.dsp_clk_stopped(dsp_clk_stopped), .dsp_pc_hold(dsp_pc_hold),
		.supervisor_enable(supervisor_enable), .periph_reset(periph_reset),
		.init_state(init_state), .seq_busy(seq_busy));
	// Oscillator runs from time zero
	initial clk = 1'b0;
	always #20 clk = ~clk;
	// Report and end the run
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Packed as periph_reset, init_state, dsp_pc_hold, supervisor_enable
	task automatic chk_pin(input logic [5:0] exp);
		comparisons++;
		if ({periph_reset, init_state, dsp_pc_hold, supervisor_enable} !== exp || seq_busy !== periph_reset) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time,
				{seq_busy, periph_reset, init_state, dsp_pc_hold, supervisor_enable}, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, lo);
		end
	endtask
	// Register write, strobe held for one taken edge
	task automatic wr(input logic [23:0] a, input logic [23:0] v);
		@(posedge clk);
		#1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask
	// Register read, data one edge after the taken edge
	task automatic rd(input logic [23:0] a, output logic [23:0] v);
		@(posedge clk);
		#1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk);
		#1 reg_rd = 1'b0;
		@(posedge clk);
		#1 v = reg_rdata;
	endtask
	// Count clocks until the internal reset drops
	task automatic wait_done(output int k);
		k = 0;
		while (periph_reset !== 1'b0 && k < 4000) begin
			@(posedge clk);
			#1 k++;
		end
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		{rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata, dsp_clk_stopped} = {4'b1100, 50'h0};
		repeat (12) @(posedge clk);
		#1 chk_pin(6'b1_0_11_00);
		rst = 1'b0;
		wait_done(n);
		chk_cnt(n, AUD + 2045, AUD + 2056);
		chk_pin(6'b0_1_11_00);
		wr(crs_pkg::RUN_CTRL_ADDR, 24'h00_0001);
		settle(2);
		chk_pin(6'b0_0_10_01);
		rd(crs_pkg::RUN_CTRL_ADDR, d);
		chk_reg(d, 24'h00_0001);
		rd(crs_pkg::STATUS_ADDR, d);
		// Locked and late: the sequence outlasted the short release limit
		chk_reg(d, 24'h00_0006);
		rd(24'h00_0012, d);
		chk_reg(d, 24'h00_0000);
		dsp_clk_stopped = 2'b01;
		settle(2);
		chk_pin(6'b0_0_10_00);
		dsp_clk_stopped = 2'b00;
		host.pulse(39);
		settle(6);
		chk_pin(6'b0_0_10_01);
		host.pulse(60);
		#1 chk_pin(6'b1_0_11_00);
		// Pin reset clears late, locks are lost, busy is set
		rd(crs_pkg::STATUS_ADDR, d);
		chk_reg(d, 24'h00_0008);
		wr(crs_pkg::RUN_CTRL_ADDR, 24'h00_0003);
		wait_done(n);
		chk_cnt(n, AUD + 2040, crs_pkg::RELEASE_CYCLES);
		chk_pin(6'b0_1_11_00);
		rd(crs_pkg::RUN_CTRL_ADDR, d);
		chk_reg(d, crs_pkg::RUN_CTRL_RESET);
		wr(crs_pkg::RUN_CTRL_ADDR, 24'h00_0003);
		settle(2);
		chk_pin(6'b0_0_00_11);
		// Clock enable low freezes everything, so the write is not taken
		ce = 1'b0;
		wr(crs_pkg::RUN_CTRL_ADDR, 24'h00_0002);
		settle(2);
		chk_pin(6'b0_0_00_11);
		ce = 1'b1;
		// Write while running holds the first processor again
		wr(crs_pkg::RUN_CTRL_ADDR, 24'h00_0002);
		settle(2);
		chk_pin(6'b0_0_01_10);
		wrap_up();
	end
endmodule
